// [tsc_consts.svh]
// Constants of the two-speed shift controller
// What this block does
// - Pick first or second from transmission speed.
// - No engagement from neutral above engine lockout.
// - Block direction change above threshold; indicate it.
// - Upshift indicator above upshift threshold.
// - Downshift indicator below downshift threshold.
// - Sensor-check indicator above sensor threshold.
// - Engine-lock indicator above engine lockout threshold.
// - Seven separate display outputs.
// - Four independent valve outputs.
// - Range strap sets meaning of range level.
// - Neutral polarity strap sets gear-request meaning.
// - Neutral source: gear-request pin or directions.
// - Inching strap sets pedal signal polarity.
// - Error reaction: go neutral or stay.
// - Range outputs held or dropped in neutral.
// - Engine sensor: direct or pickup input.
// - Transmission sensor: direct or pickup input.
// - Engine lockout threshold limited to 500-2000 rpm.
// - Direction and sensor thresholds 50-500 rpm.
`ifndef TSC_CONSTS_SVH
`define TSC_CONSTS_SVH

// Register byte offsets
`define TSC_OFS_STRAPS 8'h00
`define TSC_OFS_LOCKOUT 8'h04
`define TSC_OFS_DIR_THR 8'h08
`define TSC_OFS_SENS_THR 8'h0C
`define TSC_OFS_UP_THR 8'h10
`define TSC_OFS_DOWN_THR 8'h14
`define TSC_OFS_STATUS 8'h18
`define TSC_OFS_SPEEDS 8'h1C

// Strap bit positions, 0 = pins 1-2, 1 = pins 2-3
`define TSC_STRAP_RANGE 0
`define TSC_STRAP_NPOL 1
`define TSC_STRAP_NSRC 2
`define TSC_STRAP_INCH 3
`define TSC_STRAP_ERR 4
`define TSC_STRAP_NHOLD 5
`define TSC_STRAP_ENGINE 6
`define TSC_STRAP_TRANS 7

// Reset values
`define TSC_RST_STRAPS 8'h94
`define TSC_RST_LOCKOUT 16'h05DC
`define TSC_RST_DIR_THR 16'h00C8
`define TSC_RST_SENS_THR 16'h0064
`define TSC_RST_UP_THR 16'h0258
`define TSC_RST_DOWN_THR 16'h0190

// Threshold limits in rpm
`define TSC_LOCKOUT_MIN 16'h01F4
`define TSC_LOCKOUT_MAX 16'h07D0
`define TSC_SLOW_MIN 16'h0032
`define TSC_SLOW_MAX 16'h01F4

// Timing: 60 pulses per rev over a 1000 ms gate gives rpm directly
`define TSC_CLK_MHZ 100
`define TSC_GATE_MS 1000
`define TSC_GATE_CYCLES (`TSC_GATE_MS * `TSC_CLK_MHZ * 1000)

`endif

// [tsc_pkg.sv]
// Types of the two-speed shift controller
package tsc_pkg;

   // Engaged direction
   typedef enum logic [1:0] {
      TSC_NEUTRAL,
      TSC_FORWARD,
      TSC_REVERSE
   } tsc_dir_t;

   // Measured speed in rpm
   typedef logic [15:0] tsc_rpm_t;

endpackage : tsc_pkg

// [tsc_meter_if.sv]
// Link between controller and one speed meter
`timescale 1ns/100ps
`default_nettype none
interface tsc_meter_if;
   logic pulse;
   logic [15:0] count;
   logic upd;

   modport meter (input pulse, output count, output upd);
   modport user (output pulse, input count, input upd);
endinterface : tsc_meter_if
`default_nettype wire

// [tsc_speed_meter.sv]
// Pulse counter over a fixed gate interval
`timescale 1ns/100ps
`default_nettype none
module tsc_speed_meter #(
   parameter int unsigned GATE_CYCLES = 100
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Sensor pulse in, count out
   tsc_meter_if.meter mif
);
   logic pulse_d_ff;
   logic [31:0] gate_ff;
   logic [15:0] edges_ff;
   logic rise;
   logic gate_end;

   assign rise = mif.pulse & ~pulse_d_ff;
   assign gate_end = (gate_ff == 32'(GATE_CYCLES - 1));

   // Previous pulse level
   always_ff @(posedge clk) begin
      if (srst) pulse_d_ff <= 1'b0;
      else pulse_d_ff <= mif.pulse;
   end

   // Gate interval counter
   always_ff @(posedge clk) begin
      if (srst || gate_end) gate_ff <= 32'h0000_0000;
      else gate_ff <= gate_ff + 32'h0000_0001;
   end

   always_ff @(posedge clk) begin
      if (srst) edges_ff <= 16'h0000;
      else if (gate_end) edges_ff <= {15'h0000, rise};
      else if (rise && edges_ff != 16'hFFFF) edges_ff <= edges_ff + 16'h0001;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         mif.count <= 16'h0000;
         mif.upd <= 1'b0;
      end else begin
         mif.upd <= gate_end;
         if (gate_end) mif.count <= edges_ff;
      end
   end

endmodule : tsc_speed_meter
`default_nettype wire

// [tsc_shift_ctrl.sv]
// Two-speed powershift controller top with AHB-Lite registers
//
// The implementer's own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "tsc_consts.svh"
module tsc_shift_ctrl import tsc_pkg::*; #(
   parameter int unsigned GATE_CYCLES = `TSC_GATE_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Shifter and pedal
   input wire logic shift_fwd,
   input wire logic shift_rev,
   input wire logic shift_range,
   input wire logic gear_request,
   input wire logic inching_pedal,
   // Speed sensors
   input wire logic engine_pnp,
   input wire logic engine_mag,
   input wire logic trans_pnp,
   input wire logic trans_mag,
   // Valve bank
   output logic valve_fwd,
   output logic valve_rev,
   output logic valve_first,
   output logic valve_second,
   // Indicators
   output logic upshift_ind,
   output logic downshift_ind,
   output logic sensor_check_ind,
   output logic engine_lock_indicator,
   output logic dir_protect_ind,
   // Display
   output logic disp_sens_fault,
   output logic disp_inching,
   output logic disp_first_lock,
   output logic disp_rev,
   output logic disp_fwd,
   output logic disp_first,
   output logic disp_second
);

   // Clamp a written threshold into its allowed range
   function automatic tsc_rpm_t clamp_rpm(input tsc_rpm_t val,
                                          input tsc_rpm_t lo,
                                          input tsc_rpm_t hi);
      if (val < lo) clamp_rpm = lo;
      else if (val > hi) clamp_rpm = hi;
      else clamp_rpm = val;
   endfunction : clamp_rpm

   // Registers
   logic [7:0] straps_ff;
   tsc_rpm_t lockout_ff;
   tsc_rpm_t dir_thr_ff;
   tsc_rpm_t sens_thr_ff;
   tsc_rpm_t up_thr_ff;
   tsc_rpm_t down_thr_ff;

   // Bus state
   logic wr_pend_ff;
   logic [7:0] wr_addr_ff;
   logic addr_phase;
   logic [31:0] nxt_rdata;

   // Control state
   tsc_dir_t dir_ff;
   logic second_ff;
   logic sens_fault_ff;

   // Decoded requests
   logic req_second;
   logic in_gear_pin;
   logic neutral_req;
   logic inching;
   logic dir_conflict;
   logic error_now;
   logic go_neutral_on_err;
   logic engine_over;
   logic dir_over;
   tsc_rpm_t engine_rpm;
   tsc_rpm_t trans_rpm;
   logic nxt_first;
   logic nxt_second;
   logic range_on;

   // Speed meters
   tsc_meter_if engine_if ();
   tsc_meter_if trans_if ();

   assign engine_if.pulse = straps_ff[`TSC_STRAP_ENGINE] ? engine_mag
                                                          : engine_pnp;
   assign trans_if.pulse = straps_ff[`TSC_STRAP_TRANS] ? trans_mag
                                                        : trans_pnp;

   tsc_speed_meter #(.GATE_CYCLES(GATE_CYCLES)) u_engine_meter (
      .clk(clk),
      .srst(srst),
      .mif(engine_if.meter)
   );

   tsc_speed_meter #(.GATE_CYCLES(GATE_CYCLES)) u_trans_meter (
      .clk(clk),
      .srst(srst),
      .mif(trans_if.meter)
   );

   assign engine_rpm = engine_if.count;
   assign trans_rpm = trans_if.count;

   // AHB address phase qualifier, whole words only
   assign addr_phase = hsel & htrans[1] & hready & (hsize == 3'h2);

   // Register read mux for the address phase
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      unique case (haddr[7:0])
         `TSC_OFS_STRAPS: nxt_rdata = {24'h00_0000, straps_ff};
         `TSC_OFS_LOCKOUT: nxt_rdata = {16'h0000, lockout_ff};
         `TSC_OFS_DIR_THR: nxt_rdata = {16'h0000, dir_thr_ff};
         `TSC_OFS_SENS_THR: nxt_rdata = {16'h0000, sens_thr_ff};
         `TSC_OFS_UP_THR: nxt_rdata = {16'h0000, up_thr_ff};
         `TSC_OFS_DOWN_THR: nxt_rdata = {16'h0000, down_thr_ff};
         `TSC_OFS_STATUS: nxt_rdata = {13'h0000, dir_ff, sens_fault_ff,
            dir_protect_ind, engine_lock_indicator, sensor_check_ind,
            downshift_ind, upshift_ind, disp_second, disp_first,
            disp_fwd, disp_rev, disp_first_lock, disp_inching,
            disp_sens_fault, valve_second, valve_first, valve_rev,
            valve_fwd};
         `TSC_OFS_SPEEDS: nxt_rdata = {engine_rpm, trans_rpm};
         default: nxt_rdata = 32'h0000_0000;
      endcase
   end

   // Bus answers: zero wait, always OKAY
   always_ff @(posedge clk) begin
      if (srst) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Read data captured at the address phase
   always_ff @(posedge clk) begin
      if (srst) hrdata <= 32'h0000_0000;
      else if (addr_phase && !hwrite) hrdata <= nxt_rdata;
   end

   // Pending write held into the data phase
   always_ff @(posedge clk) begin
      if (srst) begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
      end else begin
         wr_pend_ff <= addr_phase & hwrite & (haddr[31:8] == 24'h00_0000);
         wr_addr_ff <= haddr[7:0];
      end
   end

   // Writable registers
   always_ff @(posedge clk) begin
      if (srst) begin
         straps_ff <= `TSC_RST_STRAPS;
         lockout_ff <= `TSC_RST_LOCKOUT;
         dir_thr_ff <= `TSC_RST_DIR_THR;
         sens_thr_ff <= `TSC_RST_SENS_THR;
         up_thr_ff <= `TSC_RST_UP_THR;
         down_thr_ff <= `TSC_RST_DOWN_THR;
      end else if (wr_pend_ff) begin
         unique case (wr_addr_ff)
            `TSC_OFS_STRAPS: straps_ff <= hwdata[7:0];
            `TSC_OFS_LOCKOUT: lockout_ff <= clamp_rpm(hwdata[15:0],
               `TSC_LOCKOUT_MIN, `TSC_LOCKOUT_MAX);
            `TSC_OFS_DIR_THR: dir_thr_ff <= clamp_rpm(hwdata[15:0],
               `TSC_SLOW_MIN, `TSC_SLOW_MAX);
            `TSC_OFS_SENS_THR: sens_thr_ff <= clamp_rpm(hwdata[15:0],
               `TSC_SLOW_MIN, `TSC_SLOW_MAX);
            `TSC_OFS_UP_THR: up_thr_ff <= hwdata[15:0];
            `TSC_OFS_DOWN_THR: down_thr_ff <= hwdata[15:0];
            default: ;
         endcase
      end
   end

   // Shifter decode
   always_comb begin
      req_second = straps_ff[`TSC_STRAP_RANGE] ? ~shift_range
                                                : shift_range;
      in_gear_pin = straps_ff[`TSC_STRAP_NPOL] ? ~gear_request
                                                : gear_request;
      neutral_req = straps_ff[`TSC_STRAP_NSRC] ? ~(shift_fwd ^ shift_rev)
                                                : ~in_gear_pin;
      inching = straps_ff[`TSC_STRAP_INCH] ? ~inching_pedal
                                            : inching_pedal;
      dir_conflict = shift_fwd & shift_rev;
      error_now = dir_conflict | sens_fault_ff;
      go_neutral_on_err = ~straps_ff[`TSC_STRAP_ERR];
      engine_over = engine_rpm > lockout_ff;
      dir_over = trans_rpm > dir_thr_ff;
   end

   // sensor fault judged at each transmission update
   always_ff @(posedge clk) begin
      if (srst) sens_fault_ff <= 1'b0;
      else if (trans_if.upd) begin
         sens_fault_ff <= (dir_ff != TSC_NEUTRAL) &&
                          (trans_rpm == 16'h0000) &&
                          (engine_rpm > sens_thr_ff);
      end
   end

   // Direction state machine
   always_ff @(posedge clk) begin
      if (srst) dir_ff <= TSC_NEUTRAL;
      else begin
         unique case (dir_ff)
            TSC_NEUTRAL: begin
               if (!neutral_req && !inching && !error_now && !engine_over) begin
                  if (shift_fwd) dir_ff <= TSC_FORWARD;
                  else if (shift_rev) dir_ff <= TSC_REVERSE;
               end
            end
            TSC_FORWARD: begin
               if (neutral_req || inching ||
                   (error_now && go_neutral_on_err)) begin
                  dir_ff <= TSC_NEUTRAL;
               end else if (shift_rev && !dir_over) begin
                  dir_ff <= TSC_REVERSE;
               end
            end
            TSC_REVERSE: begin
               if (neutral_req || inching ||
                   (error_now && go_neutral_on_err)) begin
                  dir_ff <= TSC_NEUTRAL;
               end else if (shift_fwd && !dir_over) begin
                  dir_ff <= TSC_FORWARD;
               end
            end
            default: dir_ff <= TSC_NEUTRAL;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) second_ff <= 1'b0;
      else if (!req_second) second_ff <= 1'b0;
      else if (trans_rpm > up_thr_ff) second_ff <= 1'b1;
      else if (trans_rpm < down_thr_ff) second_ff <= 1'b0;
   end

   always_comb begin
      range_on = (dir_ff != TSC_NEUTRAL) |
                 ~straps_ff[`TSC_STRAP_NHOLD];
      nxt_second = range_on & second_ff;
      nxt_first = range_on & ~second_ff;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         valve_fwd <= 1'b0;
         valve_rev <= 1'b0;
         valve_first <= 1'b0;
         valve_second <= 1'b0;
      end else begin
         valve_fwd <= (dir_ff == TSC_FORWARD);
         valve_rev <= (dir_ff == TSC_REVERSE);
         valve_first <= nxt_first;
         valve_second <= nxt_second;
      end
   end

   // Speed indicators
   always_ff @(posedge clk) begin
      if (srst) begin
         upshift_ind <= 1'b0;
         downshift_ind <= 1'b0;
         sensor_check_ind <= 1'b0;
         engine_lock_indicator <= 1'b0;
         dir_protect_ind <= 1'b0;
      end else begin
         upshift_ind <= trans_rpm > up_thr_ff;
         downshift_ind <= trans_rpm < down_thr_ff;
         sensor_check_ind <= trans_rpm > sens_thr_ff;
         engine_lock_indicator <= engine_over;
         dir_protect_ind <= dir_over;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         disp_sens_fault <= 1'b0;
         disp_inching <= 1'b0;
         disp_first_lock <= 1'b0;
         disp_rev <= 1'b0;
         disp_fwd <= 1'b0;
         disp_first <= 1'b0;
         disp_second <= 1'b0;
      end else begin
         disp_sens_fault <= error_now;
         disp_inching <= inching;
         disp_first_lock <= ~req_second;
         disp_rev <= (dir_ff == TSC_REVERSE);
         disp_fwd <= (dir_ff == TSC_FORWARD);
         disp_first <= nxt_first;
         disp_second <= nxt_second;
      end
   end

endmodule : tsc_shift_ctrl
`default_nettype wire

// [tsc_ctrl_chk.sv]
// Port assertions for the shift controller
`timescale 1ns/100ps
`default_nettype none
module tsc_ctrl_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Watched outputs
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic valve_fwd,
   input wire logic valve_rev,
   input wire logic valve_first,
   input wire logic valve_second,
   input wire logic upshift_ind,
   input wire logic downshift_ind,
   input wire logic engine_lock_indicator,
   input wire logic dir_protect_ind,
   input wire logic disp_fwd,
   input wire logic disp_rev
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   // Valves that exclude each other
   property p_dir_excl;
      !(valve_fwd && valve_rev);
   endproperty
   a_dir_excl: assert property (p_dir_excl)
      else $error("both direction valves on");
   property p_rng_excl;
      !(valve_first && valve_second);
   endproperty
   a_rng_excl: assert property (p_rng_excl)
      else $error("both range valves on");
   // Indicators against hysteresis band
   property p_ind_excl;
      !(upshift_ind && downshift_ind);
   endproperty
   a_ind_excl: assert property (p_ind_excl)
      else $error("up and down indicators together");
   // Engagement from neutral only below lockout
   property p_lockout;
      (($rose(valve_fwd) && !$past(valve_rev)) ||
       ($rose(valve_rev) && !$past(valve_fwd)))
         |-> !$past(engine_lock_indicator);
   endproperty
   a_lockout: assert property (p_lockout)
      else $error("gear engaged above engine lockout");
   // Direct reversal only below threshold
   property p_interlock;
      (($rose(valve_rev) && $past(valve_fwd)) ||
       ($rose(valve_fwd) && $past(valve_rev)))
         |-> !$past(dir_protect_ind);
   endproperty
   a_interlock: assert property (p_interlock)
      else $error("direction changed above threshold");
   property p_upshift;
      $rose(valve_second) |-> $past(upshift_ind);
   endproperty
   a_upshift: assert property (p_upshift)
      else $error("second engaged below upshift speed");
   // Outputs cleared by reset
   property p_reset_clear;
      $fell(srst) |-> !(valve_fwd || valve_rev || valve_first ||
         valve_second || disp_fwd || disp_rev);
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("outputs not cleared by reset");
   property p_bus_okay;
      hreadyout && !hresp;
   endproperty
   a_bus_okay: assert property (p_bus_okay)
      else $error("bus wait or error response");

   // Main scenarios reached
   c_upshift: cover property ($rose(valve_second));
   c_reverse: cover property ($rose(valve_rev) && $past(valve_fwd));
   c_lockout: cover property (engine_lock_indicator && !valve_fwd);
endmodule : tsc_ctrl_chk

bind tsc_shift_ctrl tsc_ctrl_chk i_tsc_ctrl_chk (.*);
`default_nettype wire

// [tsc_partner.sv]
// Shifter, pedal and speed sensors on the far side
`timescale 1ns/100ps
`default_nettype none
module tsc_partner (
   // Clock
   input wire logic clk,
   // Bench requests
   input wire logic req_fwd,
   input wire logic req_rev,
   input wire logic req_range,
   input wire logic req_gear,
   input wire logic req_inch,
   input wire logic [15:0] eng_per,
   input wire logic [15:0] trans_per,
   // Shifter and pedal pins
   output logic shift_fwd,
   output logic shift_rev,
   output logic shift_range,
   output logic gear_request,
   output logic inching_pedal,
   // Sensor pins
   output logic engine_pnp,
   output logic engine_mag,
   output logic trans_pnp,
   output logic trans_mag
);
   logic [15:0] eng_ph_ff = 16'h0;
   logic [15:0] trans_ph_ff = 16'h0;

   assign shift_fwd = req_fwd;
   assign shift_rev = req_rev;
   assign shift_range = req_range;
   assign gear_request = req_gear;
   assign inching_pedal = req_inch;

   // Pulse phase, one rising edge per period
   always_ff @(posedge clk) begin
      eng_ph_ff <= (eng_ph_ff + 16'h1 >= eng_per) ? 16'h0 : eng_ph_ff + 16'h1;
   end
   always_ff @(posedge clk) begin
      trans_ph_ff <= (trans_ph_ff + 16'h1 >= trans_per) ? 16'h0 :
         trans_ph_ff + 16'h1;
   end

   // Engine on direct pin, gearbox on pickup; absent pins pulled low
   assign engine_pnp = (eng_per > 16'h1) && (eng_ph_ff == 16'h0);
   assign engine_mag = 1'b0;
   assign trans_mag = (trans_per > 16'h1) && (trans_ph_ff == 16'h0);
   assign trans_pnp = 1'b0;
endmodule : tsc_partner
`default_nettype wire

// [tsc_shift_ctrl_test.sv]
// Self-checking bench for the shift controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin \
   tests_run++; \
   if ((g) !== (e)) begin \
      fails++; \
      $display("mismatch %s exp %0h got %0h", n, e, g); \
   end \
end
module tsc_shift_ctrl_test import tsc_pkg::*;;
   localparam int GATE = 2000;
   localparam int SETTLE = 2 * GATE + 8;
   int fails = 0;
   int tests_run = 0;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic hready, hreadyout, hresp;
   logic [31:0] hrdata;
   logic req_fwd = 1'b0;
   logic req_rev = 1'b0;
   logic req_range = 1'b1;
   logic req_gear = 1'b0;
   logic req_inch = 1'b0;
   logic [15:0] eng_per = 16'h0;
   logic [15:0] trans_per = 16'h0;
   logic shift_fwd, shift_rev, shift_range, gear_request, inching_pedal;
   logic engine_pnp, engine_mag, trans_pnp, trans_mag;
   logic valve_fwd, valve_rev, valve_first, valve_second;
   logic upshift_ind, downshift_ind, sensor_check_ind;
   logic engine_lock_indicator, dir_protect_ind;
   logic disp_sens_fault, disp_inching, disp_first_lock, disp_rev;
   logic disp_fwd, disp_first, disp_second;

   // Single slave drives the bus ready
   assign hready = hreadyout;
   always #5 clk = ~clk;

   tsc_shift_ctrl #(.GATE_CYCLES(GATE)) i_tsc_shift_ctrl (.*);
   tsc_partner i_tsc_partner (.*);

   // One single-word transfer, address then data phase
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask : wr
   task automatic settle;
      repeat (SETTLE) @(posedge clk);
   endtask : settle

   task automatic t_regs;
      logic [31:0] rv [6] = '{32'h94, 32'h5DC, 32'hC8, 32'h64, 32'h258,
                             32'h190};
      logic [31:0] d;
      for (int i = 0; i < 6; i++) begin
         bus(1'b0, 8'(4 * i), 32'h0, d);
         `CHK("reset value", rv[i], d)
      end
      wr(8'h04, 32'h64);
      bus(1'b0, 8'h04, 32'h0, d);
      `CHK("lockout low clamp", 32'h1F4, d)
      wr(8'h04, 32'hBB8);
      bus(1'b0, 8'h04, 32'h0, d);
      `CHK("lockout high clamp", 32'h7D0, d)
      wr(8'h08, 32'hA);
      bus(1'b0, 8'h08, 32'h0, d);
      `CHK("dir thr clamp", 32'h32, d)
      wr(8'h08, 32'hC8);
      bus(1'b0, 8'h40, 32'h0, d);
      `CHK("unmapped read", 32'h0, d)
   endtask : t_regs

   task automatic t_engage;
      wr(8'h04, 32'h1F4);
      eng_per <= 16'h2;
      // Engine count must be above lockout before the request arrives
      settle();
      req_fwd <= 1'b1;
      repeat (8) @(posedge clk);
      `CHK("engine lock on", 1'b1, engine_lock_indicator)
      `CHK("fwd blocked", 1'b0, valve_fwd)
      eng_per <= 16'h0;
      settle();
      `CHK("fwd engaged", 1'b1, valve_fwd)
      `CHK("fwd display", 1'b1, disp_fwd)
      `CHK("engine lock off", 1'b0, engine_lock_indicator)
   endtask : t_engage

   task automatic t_dir;
      trans_per <= 16'h4;
      settle();
      `CHK("dir protect on", 1'b1, dir_protect_ind)
      `CHK("sensor check on", 1'b1, sensor_check_ind)
      `CHK("no upshift", 1'b0, upshift_ind)
      `CHK("no downshift", 1'b0, downshift_ind)
      req_fwd <= 1'b0;
      req_rev <= 1'b1;
      settle();
      `CHK("fwd held", 1'b1, valve_fwd)
      trans_per <= 16'h14;
      settle();
      `CHK("dir protect off", 1'b0, dir_protect_ind)
      `CHK("sensor check edge", 1'b0, sensor_check_ind)
      `CHK("rev engaged", 1'b1, valve_rev)
      `CHK("fwd released", 1'b0, valve_fwd)
      `CHK("rev display", 1'b1, disp_rev)
   endtask : t_dir

   task automatic t_shift;
      // thresholds left at 600 over 400
      trans_per <= 16'h2;
      settle();
      `CHK("upshift on", 1'b1, upshift_ind)
      `CHK("second engaged", 1'b1, valve_second)
      `CHK("second display", 1'b1, disp_second)
      trans_per <= 16'h4;
      settle();
      `CHK("second held", 1'b1, valve_second)
      trans_per <= 16'h8;
      settle();
      `CHK("downshift on", 1'b1, downshift_ind)
      `CHK("first engaged", 1'b1, valve_first)
      `CHK("first display", 1'b1, disp_first)
   endtask : t_shift

   task automatic t_range;
      trans_per <= 16'h2;
      req_range <= 1'b0;
      settle();
      `CHK("low level first", 1'b1, valve_first)
      `CHK("first lock display", 1'b1, disp_first_lock)
      wr(8'h00, 32'h95);
      settle();
      `CHK("low level second", 1'b1, valve_second)
      wr(8'h00, 32'h94);
      req_range <= 1'b1;
   endtask : t_range

   task automatic t_inch;
      req_inch <= 1'b1;
      settle();
      `CHK("pedal neutral", 1'b0, valve_rev)
      `CHK("inching display", 1'b1, disp_inching)
      `CHK("range held", 1'b1, valve_second)
      wr(8'h00, 32'hB4);
      settle();
      `CHK("range dropped", 1'b0, valve_second)
      wr(8'h00, 32'h9C);
      settle();
      `CHK("pedal at rest", 1'b1, valve_rev)
      req_inch <= 1'b0;
      wr(8'h00, 32'h94);
   endtask : t_inch

   task automatic t_err;
      logic [31:0] d;
      req_gear <= 1'b1;
      wr(8'h00, 32'h90);
      req_fwd <= 1'b1;
      settle();
      `CHK("error stays", 1'b1, valve_rev)
      wr(8'h00, 32'h80);
      settle();
      `CHK("error neutral", 1'b0, valve_rev)
      req_fwd <= 1'b0;
      wr(8'h00, 32'h90);
      settle();
      `CHK("gear pin engage", 1'b1, valve_rev)
      wr(8'h00, 32'h92);
      settle();
      `CHK("gear pin polarity", 1'b0, valve_rev)
      // Engaged, gearbox on silent direct pin, engine turning: fault
      eng_per <= 16'h8;
      wr(8'h00, 32'h10);
      settle();
      `CHK("sensor fault display", 1'b1, disp_sens_fault)
      `CHK("fault keeps gear", 1'b1, valve_rev)
      `CHK("trans direct input", 1'b1, downshift_ind)
      bus(1'b0, 8'h1C, 32'h0, d);
      `CHK("speeds", 32'h00FA_0000, d)
   endtask : t_err

   // Verdict and end of run
   task automatic finish_test;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test

   // Main sequence
   initial begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_engage();
      t_dir();
      t_shift();
      t_range();
      t_inch();
      t_err();
      finish_test();
   end

   // Watchdog against a hang
   initial begin
      repeat (20 * SETTLE) @(posedge clk);
      fails++;
      finish_test();
   end
endmodule : tsc_shift_ctrl_test
`default_nettype wire
